/* rtl/gop_pkg.sv */
package gop_pkg;

  // Clock and counter sizing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TW            = 20;
  localparam int unsigned BYTE_BITS     = 8;

  // Line timing, microseconds
  localparam int unsigned BREAK_LOW_MIN_US     = 4000;
  localparam int unsigned BREAK_RECOVERY_US    = 200;
  localparam int unsigned START_LOW_TIME_US    = 200;
  localparam int unsigned DATA_SETUP_DELAY_US  = 500;
  localparam int unsigned DATA_VALID_HOLD_US   = 1500;
  localparam int unsigned STOP_SETUP_DELAY_US  = 1600;
  localparam int unsigned STOP_HOLD_TIME_US    = 3100;

  // Microseconds to clock cycles, rounded up for least times
  function automatic int unsigned us_to_cyc_up(input int unsigned us);
    return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  // Microseconds to clock cycles, rounded down for longest times
  function automatic int unsigned us_to_cyc_dn(input int unsigned us);
    int unsigned c;
    c = (us * 1000) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  // Cycle counts
  localparam logic [TW-1:0] CYC_BREAK  = TW'(us_to_cyc_up(BREAK_LOW_MIN_US));
  localparam logic [TW-1:0] CYC_START  = TW'(us_to_cyc_up(START_LOW_TIME_US));
  localparam logic [TW-1:0] CYC_VALID  = TW'(us_to_cyc_dn(DATA_VALID_HOLD_US));
  localparam logic [TW-1:0] CYC_SAMPLE = TW'((us_to_cyc_up(DATA_SETUP_DELAY_US) + us_to_cyc_dn(DATA_VALID_HOLD_US)) / 2);
  localparam logic [TW-1:0] CYC_BIT    = TW'(us_to_cyc_up(STOP_HOLD_TIME_US));

  // Command byte layout
  localparam int unsigned CMD_WRITE_BIT = 7;
  localparam int unsigned ADDR_W        = 7;

  // Writable register addresses
  localparam logic [ADDR_W-1:0] ADDR_CHARGE_HIGH = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_BATTERY_ID  = 7'h04;
  localparam logic [ADDR_W-1:0] ADDR_LAST_DISCH  = 7'h05;
  localparam logic [ADDR_W-1:0] ADDR_MAG_FILTER  = 7'h0A;
  localparam logic [ADDR_W-1:0] ADDR_EDV_SELECT  = 7'h0C;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET  = 7'h39;

  // True for addresses that accept write data
  function automatic logic addr_writable(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CHARGE_HIGH) || (a == ADDR_BATTERY_ID) || (a == ADDR_LAST_DISCH) ||
           (a == ADDR_MAG_FILTER) || (a == ADDR_EDV_SELECT) || (a == ADDR_SOFT_RESET);
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BRK,
    ST_RX_WAIT,
    ST_RX_BIT,
    ST_TX_GAP,
    ST_TX_BIT
  } gop_state_e;

endpackage

/* rtl/gop_port.sv */
`timescale 1ns/1ps
// Overview of operation
// - Command byte, then one data byte.
// - No faster than 333 bits per second.
// - Bytes travel bit 0 first.
// - Long enough low period is a break.
// - Every bit begins with a low start pulse.
// - Data level valid by setup, held until hold.
// - Line high by stop setup, held until stop hold.
// - Command 03h reads the available charge byte.
// - Command bit 7 selects write or read.
// - Low seven bits address; invalid writes dropped.
module gop_port
  import gop_pkg::*;
#(
  parameter logic [TW-1:0] BREAK_CYC  = CYC_BREAK,
  parameter logic [TW-1:0] START_CYC  = CYC_START,
  parameter logic [TW-1:0] SAMPLE_CYC = CYC_SAMPLE,
  parameter logic [TW-1:0] VALID_CYC  = CYC_VALID,
  parameter logic [TW-1:0] BIT_CYC    = CYC_BIT
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic              dq_in,
  output logic                   dq_out,
  output logic                   dq_oe_n,
  output logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [7:0]        reg_rdata,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [7:0]             wr_data,
  output logic                   busy
);

  logic              sync1_q, sync2_q, prev_q;
  gop_state_e        state_q, state_d;
  logic [TW-1:0]     tmr_q, tmr_d;
  logic [TW-1:0]     low_q, low_d;
  logic [7:0]        shift_q, shift_d;
  logic [3:0]        cnt_q, cnt_d;
  logic              data_ph_q, data_ph_d;
  logic [7:0]        cmd_q, cmd_d;
  logic              wr_en_q, wr_en_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [7:0]        wr_data_q, wr_data_d;
  logic              oe_n_q, oe_n_d;
  logic              fall;

  // Pin synchroniser; edge detect only looks at the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else if (ce) begin
      sync1_q <= dq_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign fall = prev_q & ~sync2_q; // Bit reference edge

  // Next-state logic for the link engine
  always_comb begin
    state_d   = state_q;
    tmr_d     = tmr_q;
    shift_d   = shift_q;
    cnt_d     = cnt_q;
    data_ph_d = data_ph_q;
    cmd_d     = cmd_q;
    wr_en_d   = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    oe_n_d    = 1'b1;
    // Saturating low-time counter for break detection
    if (sync2_q)
      low_d = '0;
    else if (low_q != BREAK_CYC)
      low_d = low_q + TW'(1);
    else
      low_d = low_q;
    case (state_q)
      ST_IDLE: begin
      end
      ST_BRK: begin
        // Wait for the host to release after the break
        if (sync2_q) begin
          state_d   = ST_RX_WAIT;
          cnt_d     = '0;
          data_ph_d = 1'b0;
        end
      end
      ST_RX_WAIT: begin
        if (fall) begin
          state_d = ST_RX_BIT;
          tmr_d   = '0;
        end
      end
      ST_RX_BIT: begin
        if (tmr_q != BIT_CYC)
          tmr_d = tmr_q + TW'(1);
        // Single sample between setup and hold, LSB first
        if (tmr_q == SAMPLE_CYC) begin
          shift_d = {sync2_q, shift_q[7:1]};
          cnt_d   = cnt_q + 4'd1;
        end else if (tmr_q > SAMPLE_CYC && sync2_q) begin
          // Stop section reached: bit is over
          state_d = ST_RX_WAIT;
          if (cnt_q == 4'(BYTE_BITS)) begin
            cnt_d = '0;
            if (!data_ph_q) begin
              cmd_d = shift_q;
              if (shift_q[CMD_WRITE_BIT]) begin
                data_ph_d = 1'b1;
              end else begin
                state_d = ST_TX_GAP;
                tmr_d   = '0;
              end
            end else begin
              // Store only to valid addresses; dropped writes leave the outputs alone
              wr_en_d   = addr_writable(cmd_q[ADDR_W-1:0]);
              if (wr_en_d) begin
                wr_addr_d = cmd_q[ADDR_W-1:0];
                wr_data_d = shift_q;
              end
              state_d   = ST_IDLE;
            end
          end
        end
      end
      ST_TX_GAP: begin
        // One full bit time of idle line before answering
        tmr_d = tmr_q + TW'(1);
        if (tmr_q == BIT_CYC - TW'(1)) begin
          shift_d = reg_rdata;
          cnt_d   = '0;
          tmr_d   = '0;
          state_d = ST_TX_BIT;
        end
      end
      ST_TX_BIT: begin
        // Start low, then data level, then released
        if (tmr_q < START_CYC)
          oe_n_d = 1'b0;
        else if (tmr_q < VALID_CYC)
          oe_n_d = shift_q[0];
        tmr_d = tmr_q + TW'(1);
        if (tmr_q == BIT_CYC - TW'(1)) begin // Bit period meets rate limit
          tmr_d   = '0;
          shift_d = {1'b0, shift_q[7:1]};
          cnt_d   = cnt_q + 4'd1;
          if (cnt_q == 4'(BYTE_BITS - 1))
            state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // A long enough low aborts anything and starts a transaction
    if (low_q == BREAK_CYC) begin
      state_d = ST_BRK;
      oe_n_d  = 1'b1;
    end
  end

  // Link engine registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      tmr_q     <= '0;
      low_q     <= '0;
      shift_q   <= '0;
      cnt_q     <= '0;
      data_ph_q <= 1'b0;
      cmd_q     <= '0;
      wr_en_q   <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      oe_n_q    <= 1'b1;
    end else if (ce) begin
      state_q   <= state_d;
      tmr_q     <= tmr_d;
      low_q     <= low_d;
      shift_q   <= shift_d;
      cnt_q     <= cnt_d;
      data_ph_q <= data_ph_d;
      cmd_q     <= cmd_d;
      wr_en_q   <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      oe_n_q    <= oe_n_d;
    end
  end

  // Open-drain pin: only ever drives low
  assign dq_out   = 1'b0;
  assign dq_oe_n  = oe_n_q;
  assign reg_addr = cmd_q[ADDR_W-1:0];
  assign wr_en    = wr_en_q;
  assign wr_addr  = wr_addr_q;
  assign wr_data  = wr_data_q;
  assign busy     = (state_q != ST_IDLE);

endmodule

/* sim/gop_host.sv */
`timescale 1ns/1ps
module gop_host #(
  parameter int BRK  = 400,
  parameter int BITP = 320,
  parameter int SMP  = 100
) (
  input  wire logic clk,
  input  wire logic dev_oe_n,
  output wire logic dq
);
  logic drv_lo = 1'b0;
  // Host pull-up wins unless a party pulls low
  assign dq = ~(drv_lo | ~dev_oe_n);
  // Long low, then idle high before the command
  task automatic brk();
    drv_lo <= 1'b1;
    repeat (BRK) @(posedge clk);
    drv_lo <= 1'b0;
    repeat (60) @(posedge clk);
  endtask
  // One byte, bit 0 first, start pulse then level then stop
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      drv_lo <= 1'b1;
      repeat (b[i] ? 20 : 200) @(posedge clk);
      drv_lo <= 1'b0;
      repeat (b[i] ? BITP - 20 : BITP - 200) @(posedge clk);
    end
  endtask
  // Sample each device bit a fixed time after its falling edge
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (dq === 1'b1 && n < 1000) begin
        @(posedge clk);
        n++;
      end
      ok &= (dq === 1'b0);
      repeat (SMP) @(posedge clk);
      b[i] = dq;
      repeat (60) @(posedge clk);
    end
  endtask
endmodule

/* sim/gop_port_asserts.sv */
`timescale 1ns/1ps
module gop_port_chk
  import gop_pkg::*;
#(
  parameter logic [TW-1:0] BREAK_CYC = CYC_BREAK,
  parameter logic [TW-1:0] START_CYC = CYC_START,
  parameter logic [TW-1:0] VALID_CYC = CYC_VALID,
  parameter logic [TW-1:0] BIT_CYC   = CYC_BIT
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              ce,
  input wire logic              dq_in,
  input wire logic              dq_out,
  input wire logic              dq_oe_n,
  input wire logic              wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic              busy
);
  logic [TW-1:0] lo_q, lo_d, hi_q, hi_d, ln_q, ln_d;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Run lengths of device pull, device release and line low
  always_comb begin
    lo_d = dq_oe_n ? '0 : lo_q + 1'b1;
    hi_d = !dq_oe_n ? '0 : hi_q + TW'(~&hi_q);
    ln_d = dq_in ? '0 : ln_q + TW'(ce & ~&ln_q);
  end
  always_ff @(posedge clk) begin
    lo_q <= reset ? '0 : lo_d;
    hi_q <= reset ? '1 : hi_d;
    ln_q <= reset ? '0 : ln_d;
  end
  dq_low_a: assert property (dq_out == 1'b0)
    else $error("line driven high");
  wr_pulse_a: assert property (wr_en |=> !wr_en)
    else $error("write strobe too long");
  wr_addr_a: assert property (wr_en |-> wr_addr inside {7'h03, 7'h04, 7'h05, 7'h0A, 7'h0C, 7'h39})
    else $error("write to bad address");
  idle_rel_a: assert property (!busy |-> dq_oe_n)
    else $error("pull while idle");
  pull_len_a: assert property ($rose(dq_oe_n) |-> lo_q == START_CYC || lo_q == VALID_CYC)
    else $error("bad pull length");
  bit_gap_a: assert property ($fell(dq_oe_n) |-> hi_q >= BIT_CYC - VALID_CYC)
    else $error("bits too close");
  brk_seen_a: assert property (ln_q == BREAK_CYC + TW'(8) |-> busy)
    else $error("break missed");
  no_wake_a: assert property (!busy && $fell(dq_in) |=> !busy)
    else $error("woke without break");
endmodule
bind gop_port gop_port_chk #(.BREAK_CYC(BREAK_CYC), .START_CYC(START_CYC), .VALID_CYC(VALID_CYC), .BIT_CYC(BIT_CYC))
  i_gop_port_chk (.clk(clk), .reset(reset), .ce(ce), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
  .wr_en(wr_en), .wr_addr(wr_addr), .busy(busy));

/* sim/gop_port_tb.sv */
`timescale 1ns/1ps
module gop_port_tb;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] rdata = 8'h00;
  logic       ce = 1'b1;
  // Shortened line timing for simulation
  localparam logic [19:0] BRK_C = 20'd400;
  localparam logic [19:0] STA_C = 20'd20;
  localparam logic [19:0] SMP_C = 20'd100;
  localparam logic [19:0] VAL_C = 20'd150;
  localparam logic [19:0] BIT_C = 20'd300;
  logic       dq, oe_n, dq_out, wr_en, busy, ok, saw_busy;
  logic [6:0] raddr, waddr;
  logic [7:0] wdata, got;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         n_wr = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  gop_port #(.BREAK_CYC(BRK_C), .START_CYC(STA_C), .SAMPLE_CYC(SMP_C), .VALID_CYC(VAL_C),
    .BIT_CYC(BIT_C)) i_gop_port (.clk(clk), .reset(reset), .ce(ce), .dq_in(dq), .dq_out(dq_out),
    .dq_oe_n(oe_n), .reg_addr(raddr), .reg_rdata(rdata), .wr_en(wr_en), .wr_addr(waddr), .wr_data(wdata),
    .busy(busy));
  gop_host i_gop_host (.clk(clk), .dev_oe_n(oe_n), .dq(dq));
  // Count write strobes and note activity
  always @(posedge clk) begin
    n_wr += int'(wr_en === 1'b1);
    saw_busy |= (busy === 1'b1);
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A byte without a break is ignored
  task automatic t_nobreak();
    saw_busy = 1'b0;
    i_gop_host.send(8'h83);
    check("busy", {7'h0, saw_busy}, 8'h00);
  endtask
  // Clock enable low freezes the port through a whole break
  task automatic t_freeze();
    ce <= 1'b0;
    i_gop_host.brk();
    ce <= 1'b1;
    repeat (20) @(posedge clk);
    check("frozen", {7'h0, busy}, 8'h00);
  endtask
  // Read of one register, the charge register first
  task automatic t_read(input logic [6:0] a, input logic [7:0] v);
    rdata <= v;
    i_gop_host.brk();
    i_gop_host.send({1'b0, a});
    i_gop_host.recv(got, ok);
    check("start", {7'h0, ok}, 8'h01);
    check("reg_addr", {1'b0, raddr}, {1'b0, a});
    check("response", got, v);
    repeat (200) @(posedge clk);
    check("idle", {7'h0, busy}, 8'h00);
  endtask
  // Write, kept only for writable addresses
  task automatic t_write(input logic [6:0] a, input logic [7:0] d, input logic wr);
    int n0;
    n0 = n_wr;
    i_gop_host.brk();
    i_gop_host.send({1'b1, a});
    i_gop_host.send(d);
    repeat (20) @(posedge clk);
    check("wr count", 8'(n_wr - n0), {7'h0, wr});
    if (wr) begin
      check("wr_addr", {1'b0, waddr}, {1'b0, a});
      check("wr_data", wdata, d);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_nobreak();
    t_freeze();
    t_read(7'h03, 8'h65);
    t_read(7'h17, 8'h9A);
    t_write(7'h04, 8'hA5, 1'b1);
    t_write(7'h39, 8'h3C, 1'b1);
    t_write(7'h7F, 8'hFF, 1'b0);
    check("wr_addr hold", {1'b0, waddr}, 8'h39);
    check("wr_data hold", wdata, 8'h3C);
    give_verdict();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule
